// *** design/hpmw_write_master.sv ***
`timescale 1ns/1ps
// Behaviour
// (RULE1) All phase counts run on bus clock
// (RULE2) Address count programmed at least two
// (RULE3) Address phase lasts count plus one
// (RULE4) Setup count at least two, three clocks
// (RULE5) Strobe count at least one, two clocks
// (RULE6) Stall freezes address and strobe phases
// (RULE7) One more address clock after stall
// (RULE8) One more strobe clock after stall
// (RULE9) Strobe starts 3-4 clocks after select; code starts it address+setup counts+2 clocks after, at least 6
// (RULE10) Strobe active 4-5 clocks without stall
// (RULE11) Data valid 4-5 clocks before rise
// (RULE12) Data held after strobe, up to 36
// (RULE13) Recovery gap follows recovery count
// (RULE14) Address with select, valid 11-45
// (RULE15) Fixed phase order every access
module hpmw_write_master #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_b,
    input  wire logic                           ce,
    // Phase configuration
    input  wire logic [hpmw_pkg::CNT_W-1:0]     address_phase_count,
    input  wire logic [hpmw_pkg::CNT_W-1:0]     setup_phase_count,
    input  wire logic [hpmw_pkg::CNT_W-1:0]     strobe_phase_count,
    input  wire logic [hpmw_pkg::HOLD_W-1:0]    hold_phase_count,
    input  wire logic [hpmw_pkg::CNT_W-1:0]     recovery_phase_count,
    // Request side
    input  wire logic                           wr_valid,
    input  wire logic [ADDR_W-1:0]              wr_addr,
    input  wire logic [DATA_W-1:0]              wr_data,
    output logic                                wr_ready,
    output logic                                busy,
    output logic                                config_error,
    // Host port pins
    input  wire logic                           host_ready_stall,
    output logic                                host_cs_b,
    output logic                                host_data_strobe_one_b,
    output logic [DATA_W-1:0]                   host_ad_out,
    output logic                                host_ad_oe,
    output logic                                host_ale
);

    // ****************************************
    // State
    // ****************************************
    hpmw_pkg::hpmw_phase_e phase;
    hpmw_pkg::hpmw_phase_e next_phase;
    logic [DATA_W-1:0]     data_q;
    logic [DATA_W-1:0]     next_data_q;
    logic [DATA_W-1:0]     ad_q;
    logic [DATA_W-1:0]     next_ad_q;
    logic                  cs_q;
    logic                  next_cs_q;
    logic                  ds_q;
    logic                  next_ds_q;
    logic                  oe_q;
    logic                  next_oe_q;
    logic                  ale_q;
    logic                  next_ale_q;
    logic                  stall_seen;
    logic                  next_stall_seen;
    logic                  tmr_load;
    logic [hpmw_pkg::HOLD_W-1:0] tmr_value;
    logic                  tmr_hold;
    logic                  tmr_done;
    logic                  stalled_phase;

    // Widen a 4-bit count to the timer width
    function automatic logic [hpmw_pkg::HOLD_W-1:0] widen(input logic [hpmw_pkg::CNT_W-1:0] c);
        return {{(hpmw_pkg::HOLD_W-hpmw_pkg::CNT_W){1'b0}}, c};
    endfunction

    // Low settings are refused at the source rather than silently stretched
    assign config_error = (address_phase_count < hpmw_pkg::ADDR_CNT_MIN)       // RULE2
                        || (setup_phase_count < hpmw_pkg::SETUP_CNT_MIN)        // RULE4
                        || (strobe_phase_count < hpmw_pkg::STROBE_CNT_MIN)      // RULE5
                        || (hold_phase_count > hpmw_pkg::HOLD_MAX);             // RULE12

    assign stalled_phase = (phase == hpmw_pkg::HPMW_ADDR) || (phase == hpmw_pkg::HPMW_STROBE);
    assign tmr_hold      = stalled_phase && (host_ready_stall || stall_seen);  // RULE6
    assign wr_ready      = (phase == hpmw_pkg::HPMW_IDLE) && !config_error;
    assign busy          = (phase != hpmw_pkg::HPMW_IDLE);

    hpmw_phase_timer #(
        .W          (hpmw_pkg::HOLD_W)
    ) u_timer (
        .clk        (clk),
        .rst_b      (rst_b),
        .ce         (ce),
        .load       (tmr_load),
        .load_value (tmr_value),
        .hold       (tmr_hold),
        .done       (tmr_done)
    );

    // ****************************************
    // Phase sequencer
    // ****************************************
    // A timer loaded with N gives N+1 clocks in the phase
    always_comb begin
        next_phase      = phase;
        next_data_q     = data_q;
        next_ad_q       = ad_q;
        next_cs_q       = cs_q;
        next_ds_q       = ds_q;
        next_oe_q       = oe_q;
        next_ale_q      = ale_q;
        next_stall_seen = 1'b0;
        tmr_load        = 1'b0;
        tmr_value       = hpmw_pkg::HOLD_RESET;
        // Stall release leaves one extra clock in the phase
        if (stalled_phase && host_ready_stall) begin
            next_stall_seen = 1'b1;                                            // RULE7 RULE8
        end
        unique case (phase)
            hpmw_pkg::HPMW_IDLE: begin
                if (wr_valid && !config_error) begin
                    next_phase  = hpmw_pkg::HPMW_ADDR;                         // RULE15
                    next_cs_q   = 1'b1;                                        // RULE14
                    next_ad_q   = DATA_W'(wr_addr);                            // RULE14
                    next_ale_q  = 1'b1;
                    next_oe_q   = 1'b1;
                    next_data_q = wr_data;
                    tmr_load    = 1'b1;
                    tmr_value   = widen(address_phase_count);                  // RULE3
                end
            end
            hpmw_pkg::HPMW_ADDR: begin
                if (tmr_done && !host_ready_stall && !stall_seen) begin        // RULE6 RULE7
                    next_phase = hpmw_pkg::HPMW_SETUP;
                    next_ale_q = 1'b0;
                    next_ad_q  = data_q;                                       // RULE11
                    tmr_load   = 1'b1;
                    tmr_value  = widen(setup_phase_count);                     // RULE4
                end
            end
            hpmw_pkg::HPMW_SETUP: begin
                if (tmr_done) begin
                    next_phase = hpmw_pkg::HPMW_STROBE;
                    next_ds_q  = 1'b1;                                         // RULE9
                    tmr_load   = 1'b1;
                    tmr_value  = widen(strobe_phase_count);                    // RULE5 RULE10
                end
            end
            hpmw_pkg::HPMW_STROBE: begin
                if (tmr_done && !host_ready_stall && !stall_seen) begin        // RULE6 RULE8
                    next_phase = hpmw_pkg::HPMW_HOLD;
                    next_ds_q  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = hold_phase_count;                             // RULE12
                end
            end
            hpmw_pkg::HPMW_HOLD: begin
                if (tmr_done) begin
                    next_phase = hpmw_pkg::HPMW_RECOV;
                    next_cs_q  = 1'b0;
                    next_oe_q  = 1'b0;
                    tmr_load   = 1'b1;
                    tmr_value  = widen(recovery_phase_count);                  // RULE13
                end
            end
            hpmw_pkg::HPMW_RECOV: begin
                if (tmr_done) begin
                    next_phase = hpmw_pkg::HPMW_IDLE;                          // RULE13 RULE15
                end
            end
            default: begin
                next_phase = hpmw_pkg::HPMW_IDLE;
            end
        endcase
    end

    // Phase register advances only on the bus clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase      <= hpmw_pkg::HPMW_IDLE;
            data_q     <= '0;
            ad_q       <= '0;
            cs_q       <= 1'b0;
            ds_q       <= 1'b0;
            oe_q       <= 1'b0;
            ale_q      <= 1'b0;
            stall_seen <= 1'b0;
        end else if (ce) begin                                                 // RULE1
            phase      <= next_phase;
            data_q     <= next_data_q;
            ad_q       <= next_ad_q;
            cs_q       <= next_cs_q;
            ds_q       <= next_ds_q;
            oe_q       <= next_oe_q;
            ale_q      <= next_ale_q;
            stall_seen <= next_stall_seen;
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    assign host_cs_b              = !cs_q;
    assign host_data_strobe_one_b = !ds_q;
    assign host_ad_out            = ad_q;
    assign host_ad_oe             = oe_q;
    assign host_ale               = ale_q;

endmodule

// *** design/hpmw_pkg.sv ***
package hpmw_pkg;

    // ****************************************
    // Phase counts and limits
    // ****************************************
    localparam int          CNT_W           = 4;
    localparam int          HOLD_W          = 6;
    localparam logic [3:0]  ADDR_CNT_MIN    = 4'h2;
    localparam logic [3:0]  SETUP_CNT_MIN   = 4'h2;
    localparam logic [3:0]  STROBE_CNT_MIN  = 4'h1;
    localparam logic [3:0]  RESET_COUNT     = 4'h0;
    localparam logic [5:0]  HOLD_RESET      = 6'h00;
    localparam logic [5:0]  HOLD_MAX        = 6'h24;
    localparam logic [4:0]  RECOV_MAX       = 5'h11;

    // ****************************************
    // Phase sequence
    // ****************************************
    typedef enum logic [2:0] {
        HPMW_IDLE,
        HPMW_ADDR,
        HPMW_SETUP,
        HPMW_STROBE,
        HPMW_HOLD,
        HPMW_RECOV
    } hpmw_phase_e;

endpackage

// *** design/hpmw_phase_timer.sv ***
`timescale 1ns/1ps
module hpmw_phase_timer #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    input  wire logic         hold,
    // Status
    output logic              done
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // Counts down; stalls freeze the count so the phase is extended
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (!hold && count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end

    assign done = (count == '0);

endmodule

// *** test/hpmw_wm_assertions.sv ***
`timescale 1ns/1ps
module hpmw_wm_assertions (
    // Watched ports
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic        wr_ready,
    input wire logic        busy,
    input wire logic        host_ready_stall,
    input wire logic        host_cs_b,
    input wire logic        host_data_strobe_one_b,
    input wire logic [15:0] host_ad_out,
    input wire logic        host_ad_oe,
    input wire logic        host_ale
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_addr; host_ale[*3]; endsequence
    sequence s_strb; (!host_data_strobe_one_b)[*2]; endsequence
    property p_take; wr_valid && wr_ready |=>
        !host_cs_b && host_ale && host_ad_oe && host_ad_out == $past(wr_addr); endproperty
    property p_addr; $rose(host_ale) |-> s_addr; endproperty
    property p_stl_a; host_ale && host_ready_stall |=> host_ale[*2]; endproperty
    property p_setup; $fell(host_ale) |-> host_data_strobe_one_b[*3]; endproperty
    property p_strb; $fell(host_data_strobe_one_b) |-> s_strb; endproperty
    property p_stl_s; !host_data_strobe_one_b && host_ready_stall |=> s_strb; endproperty
    property p_data; !host_data_strobe_one_b |-> $stable(host_ad_out) && !host_ale && !host_cs_b; endproperty
    property p_hold; $rose(host_data_strobe_one_b) |-> !host_cs_b && host_ad_oe && $stable(host_ad_out);
    endproperty
    property p_recov; $rose(host_cs_b) |-> busy && !host_ad_oe && !wr_ready; endproperty
    property p_idle; !busy |-> host_cs_b && host_data_strobe_one_b && !host_ad_oe; endproperty
    a_take:  assert property (p_take)  else $error("address not driven with select");
    a_addr:  assert property (p_addr)  else $error("address phase too short");
    a_stl_a: assert property (p_stl_a) else $error("address phase left under stall");
    a_setup: assert property (p_setup) else $error("setup phase too short");
    a_strb:  assert property (p_strb)  else $error("strobe too short");
    a_stl_s: assert property (p_stl_s) else $error("strobe left under stall");
    a_data:  assert property (p_data)  else $error("data moved during strobe");
    a_hold:  assert property (p_hold)  else $error("data dropped at strobe rise");
    a_recov: assert property (p_recov) else $error("bad recovery entry");
    a_idle:  assert property (p_idle)  else $error("pins active while idle");
endmodule
bind hpmw_write_master hpmw_wm_assertions u_chk (.clk(clk), .rst_b(rst_b), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_ready(wr_ready), .busy(busy), .host_ready_stall(host_ready_stall),
    .host_cs_b(host_cs_b), .host_data_strobe_one_b(host_data_strobe_one_b),
    .host_ad_out(host_ad_out), .host_ad_oe(host_ad_oe), .host_ale(host_ale));

// *** test/hpmw_dsp_model.sv ***
`timescale 1ns/1ps
module hpmw_dsp_model (
    // Host pins
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        cs_b,
    input wire logic        ds_b,
    input wire logic        ale,
    input wire logic [15:0] ad,
    output logic            host_ready_stall,
    // Bench side
    input wire logic        stall_en,
    output logic [15:0]     got_addr,
    output logic [15:0]     got_data
);
    int seed = 32'h77fcfc56;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_ready_stall <= 1'b0;
            got_addr <= 16'h0000;
            got_data <= 16'h0000;
        end else begin
            // Short random stalls registered from select, so one clock late; can last one clock past the frame
            host_ready_stall <= stall_en && !cs_b && ($random(seed) % 3 == 0);
            if (!cs_b && ale) got_addr <= ad;
            if (!cs_b && !ds_b) got_data <= ad;
        end
    end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst_b, wr_valid, stall_en, wr_ready, busy, cfg_err, stall, cs_b, ds_b, oe, ale;
    logic [3:0]  a_c, s_c, t_c, r_c;
    logic [5:0]  h_c;
    logic [15:0] wr_addr, wr_data, ad, got_addr, got_data;
    int          error_cnt, n_tests, seed, cs_len, rec_len, n;
    hpmw_write_master uut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .address_phase_count(a_c),
        .setup_phase_count(s_c), .strobe_phase_count(t_c), .hold_phase_count(h_c),
        .recovery_phase_count(r_c), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_ready(wr_ready), .busy(busy), .config_error(cfg_err), .host_ready_stall(stall),
        .host_cs_b(cs_b), .host_data_strobe_one_b(ds_b), .host_ad_out(ad), .host_ad_oe(oe), .host_ale(ale));
    hpmw_dsp_model dsp (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .ds_b(ds_b), .ale(ale), .ad(ad),
        .host_ready_stall(stall), .stall_en(stall_en), .got_addr(got_addr), .got_data(got_data));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk) begin
        if (!cs_b) cs_len++;
        if (busy && cs_b) rec_len++;
    end
    function automatic int exp_len(input int a, s, t, h);
        return a + s + t + h + 4;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_ready;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wr_ready !== 1'b1 && n < 300);
        if (n >= 300) begin
            error_cnt++;
            end_of_test;
        end
    endtask
    task automatic access(input logic [3:0] a, s, t, input logic [5:0] h, input logic [3:0] r, input logic st);
        @(posedge clk);
        {a_c, s_c, t_c, h_c, r_c} <= {a, s, t, h, r};
        stall_en <= st;
        wr_addr <= 16'($random(seed));
        wr_data <= 16'($random(seed));
        wr_valid <= 1'b1;
        wait_ready;
        @(posedge clk);
        wr_valid <= 1'b0;
        cs_len = 0;
        rec_len = 0;
        wait_ready;
        stall_en <= 1'b0;
        chk("addr", wr_addr, got_addr);
        chk("data", wr_data, got_data);
        chk("recov", r + 1, rec_len);
        if (!st) chk("frame", exp_len(a, s, t, h), cs_len);
        else chk("stall_frame", 1, cs_len >= exp_len(a, s, t, h));
    endtask
    initial begin
        seed = 32'h77fcfc56;
        {rst_b, wr_valid, stall_en, wr_addr, wr_data} = '0;
        {a_c, s_c, t_c, h_c, r_c} = {4'h2, 4'h2, 4'h1, 6'h00, 4'h0};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        access(4'h2, 4'h2, 4'h1, 6'h00, 4'h0, 1'b0);
        access(4'h2, 4'h2, 4'h1, 6'h24, 4'hf, 1'b1);
        for (int i = 0; i < 40; i++) begin
            access(4'h2 + 4'($random(seed) & 7), 4'h2 + 4'($random(seed) & 7), 4'h1 + 4'($random(seed) & 7),
                6'($random(seed)) % 6'h25, 4'($random(seed)), 1'($random(seed)));
        end
        // Each illegal count alone must block the request
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {a_c, s_c, t_c} <= {(k == 0) ? 4'h1 : 4'h2, (k == 1) ? 4'h1 : 4'h2, (k == 2) ? 4'h0 : 4'h1};
            h_c <= (k == 3) ? 6'h25 : 6'h00;
            wr_valid <= 1'b1;
            repeat (3) @(negedge clk);
            chk("refused_rdy", 0, wr_ready);
            chk("refused_cs", 1, cs_b);
            chk("refused_err", 1, cfg_err);
        end
        end_of_test;
    end
endmodule
